/* logic/cms_cmd_decode.sv */
`timescale 1ns/100ps
`default_nettype none
module cms_cmd_decode (
  // command in
  input wire cms_pkg::cms_cmd_t cmd,
  // verdict out
  output logic accept,
  output cms_pkg::cms_method_t new_base
);
  import cms_pkg::*;

  // ----------------------------------------------------------------
  // method character check
  // ----------------------------------------------------------------
  // only the two link-reachable codes pass; anything else, a space
  // included, is refused so the stored method stays as it is
  always_comb begin
    accept = 1'b0;
    new_base = CMS_M_PANEL;
    case (cmd.method_char)
      CMS_CHR_ZERO: begin
        accept = cmd.others_blank;
        new_base = CMS_M_PANEL;
      end
      CMS_CHR_TWO: begin
        accept = cmd.others_blank;
        new_base = CMS_M_LINK;
      end
      default: begin
        accept = 1'b0;
        new_base = CMS_M_PANEL;
      end
    endcase
  end

endmodule : cms_cmd_decode
`default_nettype wire

/* logic/cms_pkg.sv */
`default_nettype none
package cms_pkg;

  // ----------------------------------------------------------------
  // register map (byte addresses)
  // ----------------------------------------------------------------
  localparam logic [7:0] CMS_ADDR_CMD = 8'h00; // host command word
  localparam logic [7:0] CMS_ADDR_STATUS = 8'h04; // method and flags
  localparam logic [7:0] CMS_ADDR_SCHED = 8'h08; // schedule in use
  localparam logic [7:0] CMS_ADDR_REPLY = 8'h0C; // returned fields

  // ----------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------
  localparam int CMS_CMD_METHOD_LSB = 0; // method char [7:0]
  localparam int CMS_CMD_SCHED_LSB = 8; // schedule chars [23:8]
  localparam int CMS_CMD_BLANK_BIT = 24; // other items blank
  localparam int CMS_ST_ACC_BIT = 8; // last command accepted
  localparam int CMS_ST_REJ_BIT = 9; // last command refused
  localparam int CMS_ST_EXT_BIT = 12; // external control input
  localparam int CMS_ST_KEY_BIT = 13; // keyswitch input
  localparam int CMS_ST_MNT_BIT = 14; // maintenance input

  // ----------------------------------------------------------------
  // character codes and method codes
  // ----------------------------------------------------------------
  localparam logic [7:0] CMS_CHR_ZERO = 8'h30; // ascii '0'
  localparam logic [7:0] CMS_CHR_TWO = 8'h32; // ascii '2'
  localparam logic [15:0] CMS_CHR_TWO_SPACES = 16'h2020;
  localparam logic [4:0] CMS_SCHED_RST = 5'h00; // schedule after reset

  typedef enum logic [2:0] {
    CMS_M_PANEL = 3'h0, // controller control
    CMS_M_EXT_LOCAL = 3'h1, // external signals, local schedules
    CMS_M_LINK = 3'h2, // communication link
    CMS_M_MAINT = 3'h3, // maintenance
    CMS_M_EXT_HOST = 3'h5 // external signals, host schedules
  } cms_method_t;

  localparam cms_method_t CMS_METHOD_RST = CMS_M_PANEL;

  // host command as written into the command register
  typedef struct packed {
    logic others_blank; // every other item blank
    logic [15:0] sched_chars; // schedule digits, high char first
    logic [7:0] method_char; // requested method character
  } cms_cmd_t;

endpackage : cms_pkg
`default_nettype wire

/* logic/cms_selector.sv */
// The implementer's own choices: the register addresses and the APB register port.
`timescale 1ns/100ps
`default_nettype none
module cms_selector (
  // clock and reset
  input wire logic CLOCK,
  input wire logic SYS_RST,
  // apb slave
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [7:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  // front panel and external pins
  input wire logic KEYSWITCH_ON,
  input wire logic EXT_CONTROL,
  input wire logic MAINT_MODE,
  // selected control method
  output cms_pkg::cms_method_t METHOD
);
  import cms_pkg::*;

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cms_method_t base_q; // method chosen by host or panel
  cms_method_t method_q; // effective method driven out
  logic key_q; // keyswitch one cycle ago
  logic [4:0] sched_q; // schedule number in use
  logic [23:0] reply_q; // schedule and method chars returned
  logic acc_q; // last command accepted
  logic rej_q; // last command refused
  logic pready_q; // access phase answer
  logic pslverr_q; // unmapped address flag
  logic [31:0] prdata_q; // read data
  cms_cmd_t cmd; // command view of write data
  logic dec_accept; // decoder verdict
  cms_method_t dec_base; // decoder method
  logic wr_cmd; // command write takes effect
  logic wr_sched; // schedule write takes effect
  logic key_fall; // keyswitch turned off
  logic [3:0] tens; // schedule tens digit
  logic [3:0] units; // schedule units digit
  logic [15:0] sched_digits; // schedule as two ascii chars
  logic mapped; // address hits a register

  assign cmd = cms_cmd_t'(PWDATA[24:0]);
  assign key_fall = key_q & ~KEYSWITCH_ON;

  // ----------------------------------------------------------------
  // command decoder
  // ----------------------------------------------------------------
  cms_cmd_decode u_decode (
    .cmd(cmd),
    .accept(dec_accept),
    .new_base(dec_base)
  );

  // ----------------------------------------------------------------
  // apb handshake
  // ----------------------------------------------------------------
  // answer registered in setup cycle, so every access has no wait
  assign wr_cmd = PSEL & PENABLE & pready_q & PWRITE
    & (PADDR == CMS_ADDR_CMD);
  assign wr_sched = PSEL & PENABLE & pready_q & PWRITE
    & (PADDR == CMS_ADDR_SCHED);
  assign mapped = (PADDR == CMS_ADDR_CMD) | (PADDR == CMS_ADDR_STATUS)
    | (PADDR == CMS_ADDR_SCHED) | (PADDR == CMS_ADDR_REPLY);

  // ready for one cycle after setup
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
    end else begin
      pready_q <= PSEL & ~PENABLE;
      pslverr_q <= PSEL & ~PENABLE & ~mapped; // unmapped answers error
    end
  end

  // ----------------------------------------------------------------
  // schedule number to ascii
  // ----------------------------------------------------------------
  always_comb begin
    if (sched_q >= 5'd30) begin
      tens = 4'h3;
      units = 4'(sched_q - 5'd30);
    end else if (sched_q >= 5'd20) begin
      tens = 4'h2;
      units = 4'(sched_q - 5'd20);
    end else if (sched_q >= 5'd10) begin
      tens = 4'h1;
      units = 4'(sched_q - 5'd10);
    end else begin
      tens = 4'h0;
      units = sched_q[3:0];
    end
    sched_digits = {CMS_CHR_ZERO | {4'h0, tens},
      CMS_CHR_ZERO | {4'h0, units}};
  end

  // ----------------------------------------------------------------
  // read data
  // ----------------------------------------------------------------
  // latched in setup so the read is stable for the whole access
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      prdata_q <= 32'h00000000;
    end else if (PSEL & ~PENABLE & ~PWRITE) begin
      prdata_q <= 32'h00000000;
      case (PADDR)
        CMS_ADDR_STATUS: begin
          prdata_q[2:0] <= method_q;
          prdata_q[CMS_ST_ACC_BIT] <= acc_q;
          prdata_q[CMS_ST_REJ_BIT] <= rej_q;
          prdata_q[CMS_ST_EXT_BIT] <= EXT_CONTROL;
          prdata_q[CMS_ST_KEY_BIT] <= KEYSWITCH_ON;
          prdata_q[CMS_ST_MNT_BIT] <= MAINT_MODE;
        end
        CMS_ADDR_SCHED: begin
          prdata_q[4:0] <= sched_q;
        end
        CMS_ADDR_REPLY: begin
          prdata_q[23:0] <= reply_q;
        end
        default: begin
          prdata_q <= 32'h00000000; // command and unmapped read zero
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // schedule in use and reply
  // ----------------------------------------------------------------
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      sched_q <= CMS_SCHED_RST;
    end else if (wr_sched) begin
      sched_q <= PWDATA[4:0];
    end
  end

  // a blank schedule field is answered with the number in use
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      reply_q <= 24'h000000;
    end else if (wr_cmd) begin
      reply_q[7:0] <= {5'h00, method_q} | CMS_CHR_ZERO;
      if (cmd.sched_chars == CMS_CHR_TWO_SPACES) begin
        reply_q[23:8] <= sched_digits;
      end else begin
        reply_q[23:8] <= cmd.sched_chars;
      end
    end
  end

  // ----------------------------------------------------------------
  // host or panel method
  // ----------------------------------------------------------------
  // only panel or link codes ever enter here, so the host can never
  // reach external or maintenance control
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      base_q <= CMS_METHOD_RST;
      key_q <= 1'b0;
      acc_q <= 1'b0;
      rej_q <= 1'b0;
    end else begin
      key_q <= KEYSWITCH_ON;
      if (wr_cmd) begin
        acc_q <= dec_accept & ~MAINT_MODE;
        rej_q <= ~(dec_accept & ~MAINT_MODE);
      end
      if (MAINT_MODE) begin
        base_q <= base_q;
      end else if (key_fall & ~EXT_CONTROL) begin
        base_q <= CMS_M_PANEL;
      end else if (wr_cmd & dec_accept) begin
        base_q <= dec_base;
      end
    end
  end

  // ----------------------------------------------------------------
  // effective method
  // ----------------------------------------------------------------
  // external control wins even over maintenance
  always_ff @(posedge CLOCK) begin
    if (SYS_RST) begin
      method_q <= CMS_METHOD_RST;
    end else if (EXT_CONTROL) begin
      if (base_q == CMS_M_LINK) begin
        method_q <= CMS_M_EXT_HOST;
      end else begin
        method_q <= CMS_M_EXT_LOCAL;
      end
    end else if (MAINT_MODE) begin
      method_q <= CMS_M_MAINT;
    end else begin
      method_q <= base_q;
    end
  end

  assign PRDATA = prdata_q;
  assign PREADY = pready_q;
  assign PSLVERR = pslverr_q;
  assign METHOD = method_q;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (SYS_RST);

  a_apb_ready: assert property (
    PSEL & ~PENABLE |=> PREADY ##1 ~PREADY)
    else $error("ready not one cycle after setup");
  a_accept_write: assert property (
    wr_cmd & dec_accept & ~MAINT_MODE & ~(key_fall & ~EXT_CONTROL)
    |=> base_q == $past(dec_base))
    else $error("accepted method not stored");
  a_reject_hold: assert property (
    wr_cmd & ~dec_accept & ~key_fall |=> $stable(base_q))
    else $error("refused command changed method");
  a_base_legal: assert property (
    base_q == CMS_M_PANEL || base_q == CMS_M_LINK)
    else $error("host reached a forbidden method");
  a_maint_freeze: assert property (
    MAINT_MODE |=> $stable(base_q))
    else $error("method changed in maintenance");
  a_key_revert: assert property (
    key_fall & ~EXT_CONTROL & ~MAINT_MODE
    |=> base_q == CMS_M_PANEL ##1 METHOD == CMS_M_PANEL
      || $past(EXT_CONTROL) || $past(MAINT_MODE))
    else $error("keyswitch off did not revert");
  a_ext_first: assert property (
    EXT_CONTROL |=> METHOD == CMS_M_EXT_LOCAL
      || METHOD == CMS_M_EXT_HOST)
    else $error("external control not selected");
  a_link_select: assert property (
    ~EXT_CONTROL & ~MAINT_MODE & base_q == CMS_M_LINK
    |=> METHOD == CMS_M_LINK)
    else $error("link control not selected");
  a_ext_zero_one: assert property (
    EXT_CONTROL & base_q == CMS_M_PANEL |=> METHOD == CMS_M_EXT_LOCAL)
    else $error("external with 0 not method 1");
  a_no_code_four: assert property (
    METHOD != 3'h4 && METHOD <= 3'h5)
    else $error("unused method code driven");
  // digits worked out apart from the converter, so a broken one trips
  a_sched_echo: assert property (
    wr_cmd & cmd.sched_chars == CMS_CHR_TWO_SPACES
    |=> reply_q[23:8] == {CMS_CHR_ZERO | {3'h0, sched_q / 5'd10},
      CMS_CHR_ZERO | {3'h0, sched_q % 5'd10}})
    else $error("blank schedule not answered");

  c_accept: cover property (wr_cmd & dec_accept & ~MAINT_MODE);
  c_reject: cover property (wr_cmd & ~dec_accept);
  c_key_revert: cover property (key_fall & ~EXT_CONTROL
    & base_q == CMS_M_LINK);
  c_ext_host: cover property (METHOD == CMS_M_EXT_HOST);

endmodule : cms_selector
`default_nettype wire

/* sim/cms_host_model.sv */
`timescale 1ns/100ps
`default_nettype none
module cms_host_model
  import cms_pkg::*;
(
  // clock
  input wire logic clock,
  // apb requester side
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  // apb answer
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // ------------------------------------------------------------
  // host side of the link, idle at time zero
  // ------------------------------------------------------------
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h00000000;
  end

  // change request: every other item left as spaces, blank flag taken from blank
  function automatic logic [31:0] cmd_word(input logic [7:0] ch,
    input logic blank);
    return {7'h00, blank, CMS_CHR_TWO_SPACES, ch};
  endfunction : cmd_word

  // one transfer; gap idles first so the host can be slow
  task automatic xfer(input int gap, input logic w, input logic [7:0] a,
    input logic [31:0] d, output logic [31:0] r, output logic [1:0] st);
    int n;
    n = 0;
    repeat (gap) @(posedge clock);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    // bounded wait so a dead slave cannot hang the run
    while (!pready && n < 20) begin
      n++;
      @(posedge clock);
    end
    st = {pready !== 1'b1, pslverr};
    r = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
    // released data must not look like the last word
    pwdata <= ~d;
    // let the release reach an edge before the next setup drives
    @(posedge clock);
  endtask : xfer
endmodule : cms_host_model
`default_nettype wire

/* sim/tb_control_method_selector.sv */
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin n_compared++; if ((g) !== (e)) begin err_count++; \
  $display("BAD %0t got %h exp %h", $time, g, e); end end
module tb_control_method_selector;
  import cms_pkg::*;
  // ------------------------------------------------------------
  // clock, reset, pins and bus
  // ------------------------------------------------------------
  logic clock = 1'b0; // 4 ns period
  logic sys_rst = 1'b1; // held three cycles
  logic key_on = 1'b1;
  logic ext_ctl = 1'b0;
  logic maint = 1'b0;
  logic psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd_v;
  cms_method_t method;
  int gap = 0; // idle cycles before each transfer
  int err_count = 0;
  int n_compared = 0;
  always #2 clock = ~clock;

  cms_selector DUT (.CLOCK(clock), .SYS_RST(sys_rst), .PSEL(psel),
    .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .KEYSWITCH_ON(key_on), .EXT_CONTROL(ext_ctl), .MAINT_MODE(maint),
    .METHOD(method));
  cms_host_model host (.clock(clock), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr));

  task automatic stop_test();
    if (err_count == 0 && n_compared > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : stop_test

  // ------------------------------------------------------------
  // bus helpers
  // ------------------------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [31:0] d, input logic eslv);
    logic [1:0] st;
    host.xfer(gap, w, a, d, rd_v, st);
    if (st[1]) begin
      err_count++;
      stop_test();
    end
    `CHK(st[0], eslv)
  endtask : bus

  // command, then time for base and method registers to follow
  task automatic send(input logic [7:0] ch, input logic blank);
    bus(1'b1, CMS_ADDR_CMD, host.cmd_word(ch, blank), 1'b0);
    repeat (4) @(posedge clock);
  endtask : send

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic s_reset();
    `CHK(method, CMS_M_PANEL)
    bus(1'b0, CMS_ADDR_STATUS, 32'h0, 1'b0);
    `CHK(rd_v[2:0], 3'h0)
  endtask : s_reset

  task automatic s_accept();
    send(CMS_CHR_TWO, 1'b1);
    `CHK(method, CMS_M_LINK)
    bus(1'b0, CMS_ADDR_STATUS, 32'h0, 1'b0);
    `CHK(rd_v[9:8], 2'h1)
    gap = 3; // slow host
    send(CMS_CHR_ZERO, 1'b1);
    `CHK(method, CMS_M_PANEL)
    gap = 0;
  endtask : s_accept

  task automatic s_refuse();
    logic [7:0] bad [5] = '{8'h31, 8'h33, 8'h35, 8'h20, 8'h34};
    send(CMS_CHR_TWO, 1'b1);
    foreach (bad[i]) begin
      send(bad[i], 1'b1);
      `CHK(method, CMS_M_LINK)
      bus(1'b0, CMS_ADDR_STATUS, 32'h0, 1'b0);
      `CHK(rd_v[9:8], 2'h2)
    end
    send(CMS_CHR_ZERO, 1'b0);
    `CHK(method, CMS_M_LINK)
  endtask : s_refuse

  task automatic s_maint();
    maint <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(method, CMS_M_MAINT)
    send(CMS_CHR_ZERO, 1'b1);
    maint <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(method, CMS_M_LINK)
  endtask : s_maint

  task automatic s_ext();
    ext_ctl <= 1'b1;
    repeat (3) @(posedge clock);
    `CHK(method, CMS_M_EXT_HOST)
    send(CMS_CHR_ZERO, 1'b1);
    `CHK(method, CMS_M_EXT_LOCAL)
    send(CMS_CHR_TWO, 1'b1);
    // keyswitch off while external control holds: no revert
    key_on <= 1'b0;
    repeat (3) @(posedge clock);
    ext_ctl <= 1'b0;
    repeat (3) @(posedge clock);
    `CHK(method, CMS_M_LINK)
    key_on <= 1'b1;
    repeat (2) @(posedge clock);
    key_on <= 1'b0;
    repeat (4) @(posedge clock);
    `CHK(method, CMS_M_PANEL)
    key_on <= 1'b1;
  endtask : s_ext

  task automatic s_sched();
    bus(1'b1, CMS_ADDR_SCHED, 32'h0000000C, 1'b0);
    send(CMS_CHR_ZERO, 1'b1);
    bus(1'b0, CMS_ADDR_REPLY, 32'h0, 1'b0);
    `CHK(rd_v[23:8], 16'h3132)
    bus(1'b0, 8'h10, 32'h0, 1'b1);
    `CHK(rd_v, 32'h00000000)
  endtask : s_sched

  // reset in mid-run must drop the link method and the reply
  task automatic s_midreset();
    send(CMS_CHR_TWO, 1'b1);
    `CHK(method, CMS_M_LINK)
    sys_rst <= 1'b1;
    repeat (2) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    s_reset();
    bus(1'b0, CMS_ADDR_REPLY, 32'h0, 1'b0);
    `CHK(rd_v, 32'h00000000)
  endtask : s_midreset

  initial begin
    repeat (3) @(posedge clock);
    sys_rst <= 1'b0;
    @(posedge clock);
    s_reset();
    s_accept();
    s_refuse();
    s_maint();
    s_ext();
    s_sched();
    s_midreset();
    stop_test();
  end
endmodule : tb_control_method_selector
`default_nettype wire
